// file: core/dskhc_consts.svh
// register offsets, field positions, reset values and timing figures of the diskette host controller
`ifndef DSKHC_CONSTS_SVH
`define DSKHC_CONSTS_SVH

`define DSKHC_REG_CTRL 4'h0
`define DSKHC_REG_SEEK 4'h1
`define DSKHC_REG_STATUS 4'h2
`define DSKHC_REG_WPULSE 4'h3
`define DSKHC_REG_RCOUNT 4'h4
`define DSKHC_REG_INDEX 4'h5
`define DSKHC_REG_RES0 4'h8
`define DSKHC_REG_RES6 4'he

`define DSKHC_CTRL_MOTOR_LSB 0
`define DSKHC_CTRL_UNIT_LSB 4
`define DSKHC_CTRL_SEL_BIT 6
`define DSKHC_CTRL_HEAD_BIT 7
`define DSKHC_CTRL_WREN_BIT 8
`define DSKHC_SEEK_DIR_BIT 7

`define DSKHC_STAT_RWOK_BIT 0
`define DSKHC_STAT_SEEK_BIT 1
`define DSKHC_STAT_IRQ_BIT 2
`define DSKHC_STAT_RES_BIT 3
`define DSKHC_STAT_TERM_LSB 4
`define DSKHC_STAT_MOTOR_BIT 6
`define DSKHC_STAT_LOAD_BIT 7
`define DSKHC_STAT_SETTLE_BIT 8

`define DSKHC_RCOUNT_RST 3'h7
`define DSKHC_ST0_IDX 3'h0
`define DSKHC_TERM_MSB 7
`define DSKHC_TERM_LSB 6

`define DSKHC_CLK_KHZ 40000
`define DSKHC_HEAD_LOAD_MS 35
`define DSKHC_HEAD_SETTLE_MS 15
`define DSKHC_MOTOR_START_MS 250
`define DSKHC_STEP_MS 3
`define DSKHC_STEP_HI_CYC 24'h000028
`define DSKHC_RD_HOLD_CYC 3'h4
`define DSKHC_RD_GAP_CYC 3'h4
`define DSKHC_WDAT_CYC 4'h8

`endif

// file: core/dskhc_ctrl.sv
// diskette host controller: drive sequencing, step pulses, result byte collection
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "dskhc_consts.svh"

module dskhc_ctrl #(
  parameter int unsigned HEAD_LOAD_CYC = `DSKHC_HEAD_LOAD_MS * `DSKHC_CLK_KHZ,
  parameter int unsigned HEAD_SETTLE_CYC = `DSKHC_HEAD_SETTLE_MS * `DSKHC_CLK_KHZ,
  parameter int unsigned MOTOR_START_CYC = `DSKHC_MOTOR_START_MS * `DSKHC_CLK_KHZ,
  parameter int unsigned STEP_CYC = `DSKHC_STEP_MS * `DSKHC_CLK_KHZ
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic DEV_IRQ_I,
  input wire logic [7:0] DEV_DATA_I,
  output logic DEV_RD_O,
  input wire logic INDEX_I,
  output logic [3:0] MOTOR_EN_O,
  output logic [3:0] DRIVE_SEL_O,
  output logic STEP_O,
  output logic DIR_O,
  output logic HEAD_SEL_N_O,
  output logic WR_EN_O,
  output logic WR_DATA_O,
  output logic RW_OK_O
);
  import dskhc_pkg::*;

  dskhc_state_t s_r;
  dskhc_state_t s_nxt;
  logic selected;
  logic rw_ok;
  logic [15:0] status;

  function automatic logic [23:0] dec24(input logic [23:0] v);
    dec24 = (v == 24'h000000) ? 24'h000000 : v - 24'h000001;
  endfunction

  // selection only counts while that unit's motor runs
  assign selected = s_r.sel_en & s_r.motor[s_r.unit];

  assign rw_ok = selected && s_r.motor_cnt == 24'h000000
    && s_r.load_cnt == 24'h000000
    && s_r.settle_cnt == 24'h000000
    && s_r.seek == SEEK_IDLE;

  always_comb begin
    status = 16'h0000;
    status[`DSKHC_STAT_RWOK_BIT] = rw_ok;
    status[`DSKHC_STAT_SEEK_BIT] = s_r.seek != SEEK_IDLE;
    status[`DSKHC_STAT_IRQ_BIT] = s_r.irq_s2;
    status[`DSKHC_STAT_RES_BIT] = s_r.res_valid;
    // termination class of the first result byte
    status[`DSKHC_STAT_TERM_LSB +: 2] =
      s_r.bytes[`DSKHC_ST0_IDX][`DSKHC_TERM_MSB:`DSKHC_TERM_LSB];
    status[`DSKHC_STAT_MOTOR_BIT] = s_r.motor_cnt == 24'h000000;
    status[`DSKHC_STAT_LOAD_BIT] = s_r.load_cnt == 24'h000000;
    status[`DSKHC_STAT_SETTLE_BIT] = s_r.settle_cnt == 24'h000000;
  end

  always_comb begin
    s_nxt = s_r;
    // pin inputs pass two flops; only the second is read, and index adds a third for its edge
    s_nxt.irq_s1 = DEV_IRQ_I;
    s_nxt.irq_s2 = s_r.irq_s1;
    s_nxt.dat_s1 = DEV_DATA_I;
    s_nxt.dat_s2 = s_r.dat_s1;
    s_nxt.idx_s1 = INDEX_I;
    s_nxt.idx_s2 = s_r.idx_s1;
    s_nxt.idx_d = s_r.idx_s2;
    if (s_r.idx_s2 && !s_r.idx_d) begin
      s_nxt.idx_count = s_r.idx_count + 16'h0001;
    end

    // software writes
    if (WR_I) begin
      case (ADDR_I)
        `DSKHC_REG_CTRL: begin
          s_nxt.motor = WDATA_I[`DSKHC_CTRL_MOTOR_LSB +: 4];
          s_nxt.unit = WDATA_I[`DSKHC_CTRL_UNIT_LSB +: 2];
          s_nxt.sel_en = WDATA_I[`DSKHC_CTRL_SEL_BIT];
          s_nxt.head_up = WDATA_I[`DSKHC_CTRL_HEAD_BIT];
          s_nxt.wr_req = WDATA_I[`DSKHC_CTRL_WREN_BIT];
        end
        `DSKHC_REG_SEEK: begin
          // a seek is taken only while idle; a write during a seek is dropped
          if (s_r.seek == SEEK_IDLE && WDATA_I[6:0] != 7'h00 && selected) begin
            s_nxt.steps = WDATA_I[6:0];
            s_nxt.dir = WDATA_I[`DSKHC_SEEK_DIR_BIT];
            s_nxt.seek = SEEK_HIGH;
            s_nxt.step_cnt = `DSKHC_STEP_HI_CYC;
          end
        end
        `DSKHC_REG_WPULSE: begin
          if (WR_EN_O) begin
            s_nxt.wdat_cnt = `DSKHC_WDAT_CYC;
          end
        end
        `DSKHC_REG_RCOUNT: begin
          s_nxt.res_num = (WDATA_I[2:0] == 3'h0) ? 3'h1 : WDATA_I[2:0];
        end
        default: begin
        end
      endcase
    end

    // motor start wait restarts whenever the chosen unit's motor is off
    if (!s_nxt.motor[s_nxt.unit]) begin
      s_nxt.motor_cnt = 24'(MOTOR_START_CYC);
    end else begin
      s_nxt.motor_cnt = dec24(s_r.motor_cnt);
    end
    // head load wait restarts on deselect or a change of unit
    if (!s_nxt.sel_en || !s_nxt.motor[s_nxt.unit] || s_nxt.unit != s_r.unit) begin
      s_nxt.load_cnt = 24'(HEAD_LOAD_CYC);
    end else begin
      s_nxt.load_cnt = dec24(s_r.load_cnt);
    end
    s_nxt.settle_cnt = dec24(s_r.settle_cnt);

    // step pulse train, settle wait after the last step
    case (s_r.seek)
      SEEK_IDLE: begin
      end
      SEEK_HIGH: begin
        s_nxt.step_cnt = dec24(s_r.step_cnt);
        if (s_r.step_cnt == 24'h000001) begin
          s_nxt.seek = SEEK_LOW;
          s_nxt.step_cnt = 24'(STEP_CYC) - `DSKHC_STEP_HI_CYC;
          s_nxt.steps = s_r.steps - 7'h01;
        end
      end
      SEEK_LOW: begin
        s_nxt.step_cnt = dec24(s_r.step_cnt);
        if (s_r.step_cnt == 24'h000001) begin
          if (s_r.steps == 7'h00) begin
            s_nxt.seek = SEEK_IDLE;
            s_nxt.settle_cnt = 24'(HEAD_SETTLE_CYC);
          end else begin
            s_nxt.seek = SEEK_HIGH;
            s_nxt.step_cnt = `DSKHC_STEP_HI_CYC;
          end
        end
      end
      default: begin
        s_nxt.seek = SEEK_IDLE;
      end
    endcase

    // write data pulse, dropped at once if write enable falls
    if (s_r.wdat_cnt != 4'h0) begin
      s_nxt.wdat_cnt = WR_EN_O ? s_r.wdat_cnt - 4'h1 : 4'h0;
    end

    // result collection: reading the bytes is what clears the device request
    case (s_r.res)
      RES_IDLE: begin
        if (s_r.irq_s2) begin
          s_nxt.res = RES_PULSE;
          s_nxt.byte_idx = 3'h0;
          s_nxt.res_valid = 1'b0;
          s_nxt.rd_cnt = `DSKHC_RD_HOLD_CYC;
        end
      end
      RES_PULSE: begin
        s_nxt.rd_cnt = s_r.rd_cnt - 3'h1;
        if (s_r.rd_cnt == 3'h1) begin
          // byte kept as sent: error flags of the result error byte intact
          s_nxt.bytes[s_r.byte_idx] = s_r.dat_s2;
          s_nxt.res = RES_GAP;
          s_nxt.rd_cnt = `DSKHC_RD_GAP_CYC;
        end
      end
      RES_GAP: begin
        s_nxt.rd_cnt = s_r.rd_cnt - 3'h1;
        if (s_r.rd_cnt == 3'h1) begin
          if (s_r.byte_idx + 3'h1 == s_r.res_num) begin
            s_nxt.res = RES_DONE;
            s_nxt.res_valid = 1'b1;
          end else begin
            s_nxt.byte_idx = s_r.byte_idx + 3'h1;
            s_nxt.res = RES_PULSE;
            s_nxt.rd_cnt = `DSKHC_RD_HOLD_CYC;
          end
        end
      end
      RES_DONE: begin
        // wait for the request to drop so one completion is read once
        if (!s_r.irq_s2) begin
          s_nxt.res = RES_IDLE;
        end
      end
      default: begin
        s_nxt.res = RES_IDLE;
      end
    endcase

    // read data stand one cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (RD_I) begin
      case (ADDR_I)
        `DSKHC_REG_CTRL: begin
          s_nxt.rdata = {7'h00, s_r.wr_req, s_r.head_up, s_r.sel_en, s_r.unit, s_r.motor};
        end
        `DSKHC_REG_SEEK: s_nxt.rdata = {8'h00, s_r.dir, s_r.steps};
        `DSKHC_REG_STATUS: s_nxt.rdata = status;
        `DSKHC_REG_RCOUNT: s_nxt.rdata = {13'h0000, s_r.res_num};
        `DSKHC_REG_INDEX: s_nxt.rdata = s_r.idx_count;
        default: begin
          if (ADDR_I >= `DSKHC_REG_RES0 && ADDR_I <= `DSKHC_REG_RES6) begin
            s_nxt.rdata = {8'h00, s_r.bytes[ADDR_I[2:0]]};
          end
        end
      endcase
    end

    if (RST_I) begin
      s_nxt = '0;
      s_nxt.res_num = `DSKHC_RCOUNT_RST;
      s_nxt.motor_cnt = 24'(MOTOR_START_CYC);
      s_nxt.load_cnt = 24'(HEAD_LOAD_CYC);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    s_r <= s_nxt;
  end

  assign RDATA_O = s_r.rdata;
  assign DEV_RD_O = s_r.res == RES_PULSE;
  assign MOTOR_EN_O = s_r.motor;
  // only a running unit is selected; others see only motor enable
  assign DRIVE_SEL_O = selected ? (4'h1 << s_r.unit) : 4'h0;
  assign STEP_O = s_r.seek == SEEK_HIGH;
  assign DIR_O = s_r.dir;
  assign HEAD_SEL_N_O = ~s_r.head_up;
  assign WR_EN_O = s_r.wr_req & rw_ok;
  // gated here too, so the pulse never outlives write enable by a cycle
  assign WR_DATA_O = (s_r.wdat_cnt != 4'h0) & WR_EN_O;
  assign RW_OK_O = rw_ok;
endmodule

// file: core/dskhc_pkg.sv
// types of the diskette host controller
package dskhc_pkg;
  typedef enum logic [1:0] {
    SEEK_IDLE = 2'b00,
    SEEK_HIGH = 2'b01,
    SEEK_LOW = 2'b11
  } dskhc_seek_t;

  typedef enum logic [1:0] {
    RES_IDLE = 2'b00,
    RES_PULSE = 2'b01,
    RES_GAP = 2'b11,
    RES_DONE = 2'b10
  } dskhc_res_t;

  typedef struct packed {
    logic irq_s1;
    logic irq_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic idx_s1;
    logic idx_s2;
    logic idx_d;
    logic [3:0] motor;
    logic [1:0] unit;
    logic sel_en;
    logic head_up;
    logic wr_req;
    dskhc_seek_t seek;
    logic [6:0] steps;
    logic dir;
    logic [23:0] step_cnt;
    logic [23:0] motor_cnt;
    logic [23:0] load_cnt;
    logic [23:0] settle_cnt;
    dskhc_res_t res;
    logic [2:0] rd_cnt;
    logic [2:0] byte_idx;
    logic [2:0] res_num;
    logic res_valid;
    logic [6:0][7:0] bytes;
    logic [3:0] wdat_cnt;
    logic [15:0] idx_count;
    logic [15:0] rdata;
  } dskhc_state_t;
endpackage

// file: testbench/dskhc_ctrl_props.sv
// port assertions for the diskette host controller
`timescale 1ns/10ps
module dskhc_ctrl_props (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic DEV_IRQ_I,
  input wire logic DEV_RD_O,
  input wire logic [3:0] MOTOR_EN_O,
  input wire logic [3:0] DRIVE_SEL_O,
  input wire logic STEP_O,
  input wire logic WR_EN_O,
  input wire logic WR_DATA_O,
  input wire logic RW_OK_O
);
  // counts high cycles of the step line
  logic [5:0] hi_r;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      hi_r <= 6'h00;
    end else begin
      hi_r <= STEP_O ? hi_r + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  sequence rd_hold;
    DEV_RD_O [*4];
  endsequence
  sequence rd_gap;
    !DEV_RD_O [*4];
  endsequence
  a_sel_needs_motor: assert property ((DRIVE_SEL_O & ~MOTOR_EN_O) == 4'h0)
    else $error("drive selected with motor off");
  a_sel_one_unit: assert property ($onehot0(DRIVE_SEL_O))
    else $error("more than one drive selected");
  a_ready_needs_sel: assert property (RW_OK_O |-> DRIVE_SEL_O != 4'h0)
    else $error("ready without a selected drive");
  a_step_blocks_rw: assert property (STEP_O |-> !RW_OK_O)
    else $error("ready while stepping");
  a_settle_after_step: assert property ($fell(STEP_O) |-> !RW_OK_O [*8])
    else $error("ready too soon after a step");
  a_step_width: assert property ($fell(STEP_O) |-> hi_r == 6'h28)
    else $error("step pulse width wrong");
  a_wren_needs_ok: assert property (WR_EN_O |-> RW_OK_O)
    else $error("write enable before waits done");
  a_wdata_gated: assert property (WR_DATA_O |-> WR_EN_O)
    else $error("write data without write enable");
  a_irq_answer: assert property ($rose(DEV_IRQ_I) |-> ##[1:5] DEV_RD_O)
    else $error("result read did not follow request");
  a_result_strobe: assert property ($rose(DEV_RD_O) |-> rd_hold ##1 rd_gap)
    else $error("result strobe shape wrong");
endmodule

// file: testbench/dskhc_ctrl_test.sv
// self-checking bench for the diskette host controller
`timescale 1ns/10ps
`include "dskhc_consts.svh"
module dskhc_ctrl_test;
  localparam int MOT = 100;
  localparam int LOAD = 50;
  localparam int SETL = 30;
  localparam int STP = 100;
  logic CLOCK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic [15:0] WDATA_I = 16'h0000;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic go = 1'b0;
  logic [1:0] term = 2'b00;
  logic [6:0] flags = 7'h00;
  logic [15:0] RDATA_O;
  logic [7:0] DEV_DATA_I;
  logic [3:0] MOTOR_EN_O, DRIVE_SEL_O;
  logic DEV_IRQ_I, DEV_RD_O, INDEX_I, STEP_O, DIR_O, HEAD_SEL_N_O, WR_EN_O, WR_DATA_O, RW_OK_O;
  logic [7:0] eb [7];
  int cmp_count = 0;
  int bad_count = 0;
  int n, p;
  dskhc_ctrl #(.HEAD_LOAD_CYC(LOAD), .HEAD_SETTLE_CYC(SETL), .MOTOR_START_CYC(MOT),
    .STEP_CYC(STP)) u_dskhc_ctrl (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DEV_IRQ_I(DEV_IRQ_I),
    .DEV_DATA_I(DEV_DATA_I), .DEV_RD_O(DEV_RD_O), .INDEX_I(INDEX_I), .MOTOR_EN_O(MOTOR_EN_O),
    .DRIVE_SEL_O(DRIVE_SEL_O), .STEP_O(STEP_O), .DIR_O(DIR_O), .HEAD_SEL_N_O(HEAD_SEL_N_O),
    .WR_EN_O(WR_EN_O), .WR_DATA_O(WR_DATA_O), .RW_OK_O(RW_OK_O));
  dskhc_dev_model u_dskhc_dev_model (.clk_i(CLOCK_I), .rst_i(RST_I), .go_i(go), .term_i(term),
    .flags_i(flags), .dev_rd_i(DEV_RD_O), .motor_i(MOTOR_EN_O), .sel_i(DRIVE_SEL_O),
    .step_i(STEP_O), .dir_i(DIR_O), .head_n_i(HEAD_SEL_N_O), .irq_o(DEV_IRQ_I),
    .data_o(DEV_DATA_I), .index_o(INDEX_I));
  initial begin
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, RDATA_O);
  endtask
  // waits for the ready flag, counting cycles and step pulses on the way
  task automatic wait_ok(input int lim);
    logic prev;
    prev = 1'b0;
    n = 0;
    p = 0;
    do begin
      @(posedge CLOCK_I);
      #1;
      n++;
      if (STEP_O === 1'b1 && !prev) p++;
      prev = STEP_O;
      if (n > lim) begin
        chk("ready flag", 16'h0001, {15'h0000, RW_OK_O});
        stop_test();
      end
    end while (RW_OK_O !== 1'b1);
  endtask
  task automatic seek(input logic [15:0] d);
    wr(`DSKHC_REG_SEEK, d);
    wait_ok(3 * STP + SETL + 50);
    chk("step pulses", 16'h0003, 16'(p));
    chk("seek time", 16'h0001, {15'h0000, n >= 3 * STP + SETL - 2});
    chk("direction", {15'h0000, d[7]}, {15'h0000, DIR_O});
    rd(`DSKHC_REG_SEEK, {8'h00, d[7], 7'h00});
    $display("test seek done");
  endtask
  initial begin
    repeat (5) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    rd(`DSKHC_REG_CTRL, 16'h0000);
    rd(`DSKHC_REG_RCOUNT, 16'h0007);
    rd(4'h6, 16'h0000);
    chk("idle head line", 16'h0001, {15'h0000, HEAD_SEL_N_O});
    $display("test reset done");
    wr(`DSKHC_REG_CTRL, 16'h0040);
    #1;
    chk("select without motor", 16'h0000, {12'h000, DRIVE_SEL_O});
    wr(`DSKHC_REG_CTRL, 16'h0041);
    wait_ok(MOT + LOAD + 20);
    chk("start wait", 16'h0001, {15'h0000, n >= MOT - 2});
    chk("selected unit", 16'h0001, {12'h000, DRIVE_SEL_O});
    $display("test select done");
    seek(16'h0083);
    seek(16'h0003);
    wr(`DSKHC_REG_CTRL, 16'h01c1);
    #1;
    chk("write and head lines", 16'h0002, {14'h0000, WR_EN_O, HEAD_SEL_N_O});
    wr(`DSKHC_REG_WPULSE, 16'h0000);
    n = 0;
    // the pulse starts on the strobe's own edge, so look before waiting
    repeat (20) begin
      #1;
      if (WR_DATA_O === 1'b1) n++;
      @(posedge CLOCK_I);
    end
    chk("write pulse", 16'h0008, 16'(n));
    $display("test write done");
    @(posedge CLOCK_I);
    ADDR_I <= `DSKHC_REG_INDEX;
    RD_I <= 1'b1;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1;
    chk("index edges", 16'h0001, {15'h0000, RDATA_O != 16'h0000});
    $display("test index done");
    for (int k = 0; k < 4; k++) begin
      @(posedge CLOCK_I);
      term <= k[1:0];
      flags <= 7'h03 << (2 * k);
      go <= 1'b1;
      @(posedge CLOCK_I);
      go <= 1'b0;
      eb = '{{k[1:0], 6'h00}, 8'h00, {1'b0, 7'h03 << (2 * k)}, 8'h3c, 8'h01, 8'h02, 8'h03};
      n = 0;
      do begin
        @(posedge CLOCK_I);
        #1;
        n++;
      end while (DEV_IRQ_I === 1'b1 && n < 300);
      chk("request released", 16'h0000, {15'h0000, DEV_IRQ_I});
      repeat (8) @(posedge CLOCK_I);
      rd(`DSKHC_REG_STATUS, 16'h01c9 | (16'(k) << 4));
      for (int b = 0; b < 7; b++) begin
        rd(`DSKHC_REG_RES0 + 4'(b), {8'h00, eb[b]});
      end
      $display("test result set done");
    end
    wr(`DSKHC_REG_RCOUNT, 16'h0000);
    rd(`DSKHC_REG_RCOUNT, 16'h0001);
    $display("test result count done");
    wr(`DSKHC_REG_CTRL, 16'h0000);
    #1;
    chk("idle drive lines", 16'h0000, {7'h00, MOTOR_EN_O, DRIVE_SEL_O, WR_EN_O});
    stop_test();
  end
endmodule
bind dskhc_ctrl dskhc_ctrl_props u_dskhc_ctrl_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .DEV_IRQ_I(DEV_IRQ_I), .DEV_RD_O(DEV_RD_O), .MOTOR_EN_O(MOTOR_EN_O),
  .DRIVE_SEL_O(DRIVE_SEL_O), .STEP_O(STEP_O), .WR_EN_O(WR_EN_O), .WR_DATA_O(WR_DATA_O),
  .RW_OK_O(RW_OK_O));

// file: testbench/dskhc_dev_model.sv
// controller chip and drive as seen from the host controller
`timescale 1ns/10ps
module dskhc_dev_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [1:0] term_i,
  input wire logic [6:0] flags_i,
  input wire logic dev_rd_i,
  input wire logic [3:0] motor_i,
  input wire logic [3:0] sel_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic head_n_i,
  output logic irq_o,
  output logic [7:0] data_o,
  output logic index_o
);
  logic [6:0][7:0] res_r;
  logic [7:0] st3, cyl_r, rev_r;
  logic [2:0] idx_r;
  logic rd_d, step_d, tog_r;
  // live drive levels; the diskette is never write protected, fault never set
  assign st3 = {2'b00, |(sel_i & motor_i), cyl_r == 8'h00, 1'b1, ~head_n_i,
    sel_i[3] | sel_i[2], sel_i[3] | sel_i[1]};
  // a released bus toggles so stale data never matches
  assign data_o = irq_o ? res_r[idx_r] : {8{tog_r}} ^ 8'ha5;
  always_ff @(posedge clk_i) begin
    rd_d <= dev_rd_i;
    step_d <= step_i;
    if (rst_i) begin
      irq_o <= 1'b0;
      idx_r <= 3'h0;
      cyl_r <= 8'h00;
      rev_r <= 8'h00;
      tog_r <= 1'b0;
      index_o <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      rev_r <= |sel_i ? rev_r + 8'h01 : 8'h00;
      index_o <= |sel_i && rev_r < 8'h04;
      if (go_i) begin
        irq_o <= 1'b1;
        idx_r <= 3'h0;
        res_r <= {8'h03, 8'h02, 8'h01, st3, {1'b0, flags_i}, 8'h00, {term_i, 6'h00}};
      end
      if (rd_d && !dev_rd_i && irq_o) begin
        idx_r <= idx_r + 3'h1;
        irq_o <= idx_r != 3'h6;
      end
      if (step_i && !step_d && |sel_i) begin
        cyl_r <= dir_i ? cyl_r + 8'h01 : cyl_r - {7'h00, cyl_r != 8'h00};
      end
    end
  end
endmodule
